/* inc/hlt_map.svh */
`ifndef HLT_MAP_SVH
`define HLT_MAP_SVH
`define HLT_MODE_W 5
`define HLT_CNT_W 8
`define HLT_CNT_RESET 8'h00
`define HLT_CLASS_FREE 2'h0
`define HLT_CLASS_ONESHOT 2'h1
`define HLT_CLASS_MONO 2'h2
`define HLT_SYNC_STAGES 2
`endif

/* inc/hlt_pkg.sv */
package hlt_pkg;
  typedef enum logic [1:0] {
    HLT_IDLE,
    HLT_ARMED,
    HLT_RUN
  } hlt_state_t;
endpackage

/* hdl/hlt_sync.sv */
`timescale 1ns/1ps
module hlt_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;
  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end
  // Stage one feeds only stage two
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

/* hdl/hlt_timer.sv */
`timescale 1ns/1ps
`include "hlt_map.svh"
// Operation
// - Mode 00000 counts each timer clock while run is set and holds while clear.
// - In free-running modes a count equal to the period goes to zero next tick.
// - Modes 00001/00010 count only while run is set and the external gate is high/low.
// - Modes 00011/00100/00101 run with run set and clear on any/rising/falling edge.
// - Modes 00110/00111 hold the counter reset while the external signal is low/high.
// - Mode 01000 starts a one-shot when run is set, with no trigger.
// - One-shot modes clear run and stop at zero on the tick after a period match.
// - Modes 01001/01010/01011 start on run plus rising/falling/any edge.
// - Modes 01100/01101 start on rising/falling edge and the same edge clears the count.
// - Mode 01110 starts rising and resets low; 01111 starts falling and resets high.
// - Edge-started modes need a fresh qualifying edge after run becomes set.
// - Modes 10001/10010/10011 are monostable, started by run plus a chosen edge.
// - Monostable modes stop at zero after a period match; 10001/10010/10011 leave run set, 10110/10111 clear it.
// - Mode 10110 starts on high and resets low; 10111 starts low and resets high.
// - Run takes effect after two timer-clock sync stages, the external signal after two core-clock sync stages.
module hlt_timer (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic timer_input_clock,
  input wire logic ext_reset_start_signal,
  input wire logic [`HLT_MODE_W-1:0] timer_mode,
  input wire logic run_set,
  input wire logic run_clear,
  input wire logic [`HLT_CNT_W-1:0] period_value,
  output logic run_bit,
  output logic [`HLT_CNT_W-1:0] count_value,
  output logic period_match_output
);
  logic rstSync1;
  logic rstLocal_n;
  logic clkSync;
  logic clkPrev;
  logic extSync;
  logic extPrev;
  logic runSync1;
  logic runSync;
  logic next_clkPrev;
  logic next_extPrev;
  logic next_runSync1;
  logic next_runSync;
  logic next_run_bit;
  logic [`HLT_CNT_W-1:0] next_count_value;
  logic next_period_match_output;
  hlt_pkg::hlt_state_t state;
  hlt_pkg::hlt_state_t next_state;
  logic tick;
  logic rise;
  logic fall;
  logic [1:0] modeClass;
  logic [2:0] variant;

  // Selects the edge named by a variant: 1 rise, 2 fall, 3 any
  function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
    logic res;
    res = 1'b0;
    unique case (sel)
      2'h1: res = r;
      2'h2: res = f;
      2'h3: res = r | f;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstLocal_n <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstLocal_n <= rstSync1;
    end
  end

  hlt_sync u_clk_sync (
    .core_clk(core_clk),
    .rst_n(rstLocal_n),
    .din(timer_input_clock),
    .dout(clkSync)
  );
  hlt_sync u_ext_sync (
    .core_clk(core_clk),
    .rst_n(rstLocal_n),
    .din(ext_reset_start_signal),
    .dout(extSync)
  );

  assign modeClass = timer_mode[4:3];
  assign variant = timer_mode[2:0];
  assign tick = clkSync & ~clkPrev;

  always_comb begin
    next_clkPrev = clkSync;
    next_extPrev = tick ? extSync : extPrev;
    next_runSync1 = tick ? run_bit : runSync1;
    next_runSync = tick ? runSync1 : runSync;
    rise = tick & extSync & ~extPrev;
    fall = tick & ~extSync & extPrev;
  end

  always_comb begin
    logic match;
    logic go;
    logic hold;
    logic clr;
    logic startEv;
    match = (count_value == period_value);
    go = 1'b0;
    hold = 1'b0;
    clr = 1'b0;
    startEv = 1'b0;
    next_state = state;
    next_count_value = count_value;
    next_period_match_output = 1'b0;
    // Software set wins over a simultaneous clear so a start is never lost
    next_run_bit = run_set | (run_bit & ~run_clear);
    unique case (modeClass)
      `HLT_CLASS_FREE: begin
        unique case (variant)
          3'h0: go = runSync;
          3'h1: go = runSync & extSync;
          3'h2: go = runSync & ~extSync;
          3'h3, 3'h4, 3'h5: begin
            go = runSync;
            clr = edge_pick(variant[1:0] == 2'h3 ? 2'h3 : (variant == 3'h4 ? 2'h1 : 2'h2),
              rise, fall);
          end
          default: begin
            go = runSync;
            hold = variant[0] ? extSync : ~extSync;
          end
        endcase
        next_state = hlt_pkg::HLT_IDLE;
      end
      `HLT_CLASS_ONESHOT, `HLT_CLASS_MONO: begin
        if (modeClass == `HLT_CLASS_ONESHOT) begin
          unique case (variant)
            3'h0: startEv = 1'b1;
            3'h1, 3'h2, 3'h3: startEv = edge_pick(variant[1:0], rise, fall);
            3'h4, 3'h5: begin
              startEv = variant[0] ? fall : rise;
              clr = startEv;
            end
            default: begin
              startEv = variant[0] ? fall : rise;
              hold = variant[0] ? extSync : ~extSync;
            end
          endcase
        end else begin
          unique case (variant)
            3'h1, 3'h2, 3'h3: startEv = edge_pick(variant[1:0], rise, fall);
            3'h6, 3'h7: begin
              startEv = variant[0] ? ~extSync : extSync;
              hold = ~startEv;
            end
            default: startEv = 1'b0;
          endcase
        end
        // arm only while run is set, fresh edge needed
        // Live run bit gates starts too: the synced copy lags and would relaunch a finished shot
        if (!runSync) begin
          next_state = hlt_pkg::HLT_IDLE;
        end else if (state == hlt_pkg::HLT_IDLE && startEv && run_bit) begin
          next_state = hlt_pkg::HLT_RUN;
        end
        go = (state == hlt_pkg::HLT_RUN) && runSync;
        if (go && tick && match) begin
          go = 1'b0;
          next_count_value = `HLT_CNT_RESET;
          next_period_match_output = 1'b1;
          next_state = hlt_pkg::HLT_IDLE;
          // one-shot clears run, level-started shots too
          if (modeClass == `HLT_CLASS_ONESHOT || variant[2:1] == 2'h3) begin
            next_run_bit = run_set;
          end
        end
      end
      default: next_state = hlt_pkg::HLT_IDLE;
    endcase
    if (hold || clr) begin
      next_count_value = `HLT_CNT_RESET;
    end else if (go && tick) begin
      if (match) begin
        next_count_value = `HLT_CNT_RESET;
        next_period_match_output = 1'b1;
      end else begin
        next_count_value = count_value + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      clkPrev <= 1'b0;
      extPrev <= 1'b0;
      runSync1 <= 1'b0;
      runSync <= 1'b0;
      run_bit <= 1'b0;
      count_value <= `HLT_CNT_RESET;
      period_match_output <= 1'b0;
      state <= hlt_pkg::HLT_IDLE;
    end else begin
      clkPrev <= next_clkPrev;
      extPrev <= next_extPrev;
      runSync1 <= next_runSync1;
      runSync <= next_runSync;
      run_bit <= next_run_bit;
      count_value <= next_count_value;
      period_match_output <= next_period_match_output;
      state <= next_state;
    end
  end
endmodule

/* sim/hlt_ext_model.sv */
`timescale 1ns/1ps
module hlt_ext_model (
  input wire logic core_clk,
  input wire logic level_req,
  output logic ext_level
);
  // Peripheral moves its line on the falling core_clk edge, so the sync never sees a tie
  always @(negedge core_clk) begin
    ext_level <= level_req;
  end
endmodule

/* sim/hlt_timer_chk.sv */
`timescale 1ns/1ps
module hlt_timer_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic timer_input_clock,
  input wire logic ext_reset_start_signal,
  input wire logic [4:0] timer_mode,
  input wire logic run_set,
  input wire logic run_clear,
  input wire logic [7:0] period_value,
  input wire logic run_bit,
  input wire logic [7:0] count_value,
  input wire logic period_match_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic rsv = timer_mode[4] && (timer_mode[3] || timer_mode[2:0] inside {3'h0, 3'h4, 3'h5});
  sequence s_hw_stop;
    $fell(run_bit) && (timer_mode[4:3] == 2'h1 || timer_mode[4:1] == 4'hb) &&
      !$past(run_clear);
  endsequence
  a_run_set_wins: assert property (run_set |=> run_bit) else $error("run not set");
  a_run_clr_drop: assert property (run_clear && !run_set |=> !run_bit)
    else $error("run kept");
  a_count_step_ok: assert property ($changed(count_value) |->
    count_value == 8'h00 || count_value == $past(count_value) + 8'h01)
    else $error("count jumped");
  a_wrap_from_period: assert property ($changed(count_value) && count_value == 8'h00 &&
    timer_mode == 5'h00 |-> $past(count_value) == $past(period_value))
    else $error("early wrap");
  a_match_one_cycle: assert property (period_match_output |=> !period_match_output)
    else $error("match too long");
  a_match_at_zero: assert property (period_match_output |-> count_value == 8'h00 &&
    $past(count_value) == $past(period_value)) else $error("match not at wrap");
  a_shot_stop_zero: assert property (s_hw_stop |-> ##[0:2] count_value == 8'h00)
    else $error("shot not stopped");
  a_mono_keep_run: assert property (timer_mode[4:3] == 2'h2 &&
    timer_mode[2:1] != 2'h3 && run_bit && !run_clear |=> run_bit)
    else $error("mono dropped run");
  a_reserved_still: assert property (rsv ##1 rsv |-> $stable(count_value) ||
    count_value == 8'h00) else $error("reserved counts");
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic coreClk = 1'h0, tmrClk = 1'h0, rstN = 1'h0;
  logic runSet = 1'h0, runClear = 1'h0, extReq = 1'h0;
  logic [4:0] mode = 5'h00;
  logic [7:0] period = 8'h03;
  logic runBit, extSig, matchOut;
  logic [7:0] count;
  int miscompares = 0, numChecks = 0;
  initial forever #10 coreClk = ~coreClk;
  initial forever #80 tmrClk = ~tmrClk;
  hlt_ext_model i_ext (.core_clk(coreClk), .level_req(extReq), .ext_level(extSig));
  hlt_timer i_dut (.core_clk(coreClk), .rst_n(rstN), .timer_input_clock(tmrClk),
    .ext_reset_start_signal(extSig), .timer_mode(mode), .run_set(runSet),
    .run_clear(runClear), .period_value(period), .run_bit(runBit), .count_value(count),
    .period_match_output(matchOut));
  task automatic wt(input int n);
    repeat (n) @(negedge coreClk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic waitCnt(input logic [7:0] v);
    for (int i = 0; i < 300 && count !== v; i++) wt(1);
  endtask
  task automatic start(input logic [4:0] m, input logic [7:0] p, input logic e);
    rstN = 0;
    mode = m;
    period = p;
    extReq = e;
    wt(20);
    rstN = 1;
    wt(4);
    runSet = 1;
    wt(1);
    runSet = 0;
  endtask
  task automatic sFree;
    logic [7:0] v;
    start(5'h00, 8'h03, 1'b0);
    waitCnt(8'h03);
    chk("count at period", 8'h03, count);
    waitCnt(8'h00);
    chk("match pulse", 8'h01, {7'h00, matchOut});
    chk("count after wrap", 8'h00, count);
    runClear = 1;
    wt(1);
    runClear = 0;
    wt(40);
    v = count;
    wt(40);
    chk("held count", v, count);
  endtask
  task automatic sLevel(input logic [4:0] m, input logic idle);
    start(m, 8'h20, idle);
    wt(60);
    chk("blocked count", 8'h00, count);
    extReq = ~idle;
    waitCnt(8'h02);
    chk("released count", 8'h02, count);
  endtask
  task automatic sEdge(input logic [4:0] m, input logic e0);
    start(m, 8'h02, e0);
    wt(60);
    chk("no edge yet", 8'h00, count);
    extReq = ~e0;
    waitCnt(8'h01);
    chk("edge started", 8'h01, count);
    wt(100);
    chk("stopped count", 8'h00, count);
    chk("run after end", {7'h00, m[4]}, {7'h00, runBit});
  endtask
  task automatic sClr(input logic [4:0] m, input logic e0);
    start(m, 8'h40, e0);
    waitCnt(8'h04);
    extReq = ~e0;
    wt(30);
    chk("edge cleared", 8'h01, {7'h00, count < 8'h04});
  endtask
  task automatic sShot;
    start(5'h08, 8'h02, 1'b0);
    waitCnt(8'h02);
    chk("shot peak", 8'h02, count);
    wt(100);
    chk("shot run", 8'h00, {7'h00, runBit});
    chk("shot stop", 8'h00, count);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  logic [4:0] lm[6] = '{5'h01, 5'h02, 5'h06, 5'h07, 5'h16, 5'h17};
  logic [4:0] em[10] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13};
  logic [9:0] e0 = 10'h152;
  logic [4:0] rm[4] = '{5'h10, 5'h14, 5'h15, 5'h18};
  task automatic sRsv;
    foreach (rm[i]) begin
      start(rm[i], 8'h02, 1'b0);
      wt(60);
      chk("reserved count", 8'h00, count);
    end
  endtask
  initial begin
    sFree();
    sShot();
    foreach (lm[i]) sLevel(lm[i], i[0]);
    foreach (em[i]) sEdge(em[i], e0[i]);
    for (int m = 3; m < 6; m++) sClr(m[4:0], m == 5);
    sRsv();
    wrap_up();
  end
  initial begin
    #600000;
    miscompares++;
    wrap_up();
  end
endmodule
bind hlt_timer hlt_timer_chk i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .timer_input_clock(timer_input_clock), .ext_reset_start_signal(ext_reset_start_signal),
  .timer_mode(timer_mode), .run_set(run_set), .run_clear(run_clear),
  .period_value(period_value), .run_bit(run_bit), .count_value(count_value),
  .period_match_output(period_match_output));
